// ---- hw/framer_pkg.sv ----
package framer_pkg;
  localparam int          BLOCK_BYTES      = 80;
  localparam int          ID_BYTES         = 3;
  localparam logic [6:0]  LAST_BYTE        = 7'h4f;
  localparam logic [2:0]  SECT_HEADER      = 3'h0;
  localparam logic [2:0]  SECT_SUBCODE     = 3'h1;
  localparam logic [2:0]  SECT_VIDEO_AUXILIARY        = 3'h2;
  localparam logic [2:0]  SECT_AUDIO       = 3'h3;
  localparam logic [2:0]  SECT_VIDEO       = 3'h4;
  localparam logic [3:0]  MAX_SEQ_60       = 4'h9;
  localparam logic [3:0]  MAX_SEQ_50       = 4'hb;
  localparam logic [3:0]  HALF_LAST_60     = 4'h4;
  localparam logic [3:0]  HALF_LAST_50     = 4'h5;
  localparam logic [2:0]  APP_RECORDER     = 3'h1;
  localparam logic [2:0]  APP_UNKNOWN      = 3'h7;
  localparam logic [7:0]  FILL_BYTE        = 8'hff;
  localparam logic [6:0]  HDR_LAST_ACTIVE  = 7'h07;
  localparam logic [6:0]  SUB_AREA_END     = 7'h33;
  localparam logic [7:0]  PACK_TIME_CODE   = 8'h13;
  localparam logic [7:0]  PACK_BIN_GROUP   = 8'h14;
  localparam logic [7:0]  PACK_AUDIO_SRC   = 8'h50;
  localparam logic [7:0]  PACK_VIDEO_SRC   = 8'h60;
  localparam logic [7:0]  PACK_NO_INFO     = 8'hff;
  localparam int          SSB_BYTES        = 8;
  localparam int          SSB_PER_BLOCK    = 6;
  localparam int          PACK_BYTES       = 5;

  typedef enum logic [1:0] {PACK_RESERVED = 2'h0, PACK_TC = 2'h1, PACK_BG = 2'h2} pack_kind_t;

  // channel number to id bits {hi,lo}
  function automatic logic [1:0] chan_to_bits(input logic [1:0] ch);
    case (ch)
      2'h0:    chan_to_bits = 2'h1;
      2'h1:    chan_to_bits = 2'h3;
      2'h2:    chan_to_bits = 2'h0;
      default: chan_to_bits = 2'h2;
    endcase
  endfunction

  function automatic logic [1:0] bits_to_chan(input logic [1:0] b);
    case (b)
      2'h1:    bits_to_chan = 2'h0;
      2'h3:    bits_to_chan = 2'h1;
      2'h0:    bits_to_chan = 2'h2;
      default: bits_to_chan = 2'h3;
    endcase
  endfunction

  // which pack sits in a sync sub-block
  function automatic pack_kind_t pack_kind(input logic [3:0] ssb, input logic first_half);
    if (ssb == 4'h3 || ssb == 4'h9)
      pack_kind = PACK_TC;
    else if (first_half && (ssb == 4'h5 || ssb == 4'hb))
      pack_kind = PACK_TC;
    else if (first_half && (ssb == 4'h4 || ssb == 4'ha))
      pack_kind = PACK_BG;
    else
      pack_kind = PACK_RESERVED;
  endfunction
endpackage

// ---- hw/stream_if.sv ----
`timescale 1ns/1ps
interface stream_if;
  logic       valid;
  logic       sob;
  logic [7:0] data;
  modport source (output valid, output sob, output data);
  modport sink   (input valid, input sob, input data);
endinterface

// ---- hw/header_subcode_framer.sv ----
`timescale 1ns/1ps
module header_subcode_framer
  import framer_pkg::*;
(
  input  wire logic        mclk,           // byte clock
  input  wire logic        rst,            // sync reset
  input  wire logic        start,          // pulse: send header and two subcode blocks
  input  wire logic        sys50,          // 1 = 50 Hz system
  input  wire logic [3:0]  seq_num,        // sequence number
  input  wire logic [1:0]  channel,        // channel 0..3
  input  wire logic        src_known,      // source is a recorder of this format
  input  wire logic        half_unknown,   // half flag information unavailable
  input  wire logic        audio_valid_flag,   // 0 valid
  input  wire logic        picture_valid_flag, // 0 valid
  input  wire logic        subcode_valid_flag, // 0 valid
  input  wire logic        frame_start,    // pulse while idle: latch new pack contents
  input  wire logic [31:0] tc_body,        // time code pack bytes 1..4
  input  wire logic [31:0] bg_body,        // binary group pack bytes 1..4
  output logic             busy,           // sending
  stream_if.source         tx              // byte stream out
);
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_HDR = 3'b010, ST_SUB = 3'b100} state_t;

  state_t      state_r;
  logic [6:0]  pos_r;
  logic        blk_r;
  logic [31:0] tc_r, bg_r;
  logic [7:0]  byte_nxt;
  logic [3:0]  ssb;
  logic [2:0]  sub_pos;
  logic [6:0]  rel;
  logic        first_half;
  logic [2:0]  app;
  logic [1:0]  chb;
  pack_kind_t  kind;

  // application code, half flag and sub-block position for the byte mux
  assign app        = src_known ? APP_RECORDER : APP_UNKNOWN;
  assign first_half = seq_num <= (sys50 ? HALF_LAST_50 : HALF_LAST_60);
  assign chb        = chan_to_bits(channel);
  assign rel        = pos_r - 7'(ID_BYTES);
  assign sub_pos    = rel[2:0];
  assign ssb        = 4'(rel[6:3]) + (blk_r ? 4'h6 : 4'h0);
  assign kind       = pack_kind(ssb, first_half);

  // pack contents only change while idle, so every copy sent within one
  // sequence carries the same value even if frame_start arrives mid-flight
  always_ff @(posedge mclk) begin
    if (rst) begin
      tc_r <= '1;
    end else if (frame_start && state_r == ST_IDLE) begin
      tc_r <= tc_body;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bg_r <= '1;
    end else if (frame_start && state_r == ST_IDLE) begin
      bg_r <= bg_body;
    end
  end

  // next byte on the link, chosen by section and position;
  // reserved and arbitrary bits go out as ones
  always_comb begin
    byte_nxt = FILL_BYTE;
    if (pos_r == 7'h00)
      byte_nxt = {(state_r == ST_HDR) ? SECT_HEADER : SECT_SUBCODE, 5'h1f};
    else if (pos_r == 7'h01)
      byte_nxt = {seq_num, chb, 2'h3};
    else if (pos_r == 7'h02)
      byte_nxt = (state_r == ST_HDR) ? 8'h00 : {7'h00, blk_r};
    else if (state_r == ST_HDR) begin
      case (pos_r)
        7'h03:   byte_nxt = {sys50, 1'b0, 6'h3f};
        7'h04:   byte_nxt = {5'h1f, app};
        7'h05:   byte_nxt = {audio_valid_flag, 4'hf, app};
        7'h06:   byte_nxt = {picture_valid_flag, 4'hf, app};
        7'h07:   byte_nxt = {subcode_valid_flag, 4'hf, app};
        default: byte_nxt = FILL_BYTE;
      endcase
    end else if (pos_r < SUB_AREA_END) begin
      case (sub_pos)
        3'h0: begin
          if (half_unknown)
            byte_nxt = FILL_BYTE;
          else if (ssb == 4'h0 || ssb == 4'h6)
            byte_nxt = {first_half, app, 4'hf};
          else if (ssb == 4'hb)
            byte_nxt = {first_half, app, 4'hf};
          else
            byte_nxt = {first_half, 7'h7f};
        end
        3'h1:    byte_nxt = {4'hf, ssb};
        3'h2:    byte_nxt = FILL_BYTE;
        3'h3: begin
          case (kind)
            PACK_TC: byte_nxt = PACK_TIME_CODE;
            PACK_BG: byte_nxt = PACK_BIN_GROUP;
            default: byte_nxt = PACK_NO_INFO;
          endcase
        end
        default: begin
          case (kind)
            PACK_TC: byte_nxt = tc_r[8*(3'h7-sub_pos) +: 8];
            PACK_BG: byte_nxt = bg_r[8*(3'h7-sub_pos) +: 8];
            default: byte_nxt = FILL_BYTE;
          endcase
        end
      endcase
    end
  end

  // byte position inside the current block
  always_ff @(posedge mclk) begin
    if (rst || state_r == ST_IDLE) begin
      pos_r <= 7'h00;
    end else begin
      pos_r <= (pos_r == LAST_BYTE) ? 7'h00 : pos_r + 7'h01;
    end
  end

  // which of the two subcode blocks is on the link
  always_ff @(posedge mclk) begin
    if (rst || state_r != ST_SUB) begin
      blk_r <= 1'b0;
    end else if (pos_r == LAST_BYTE) begin
      blk_r <= 1'b1;
    end
  end

  // section order: one header block, then two subcode blocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start)
            state_r <= ST_HDR;
        end
        ST_HDR: begin
          if (pos_r == LAST_BYTE)
            state_r <= ST_SUB;
        end
        ST_SUB: begin
          if (pos_r == LAST_BYTE && blk_r)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // link strobes
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx.valid <= 1'b0;
      tx.sob   <= 1'b0;
    end else begin
      tx.valid <= (state_r != ST_IDLE);
      tx.sob   <= (state_r != ST_IDLE) && (pos_r == 7'h00);
    end
  end

  // data reads zero outside blocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx.data <= 8'h00;
    end else begin
      tx.data <= (state_r != ST_IDLE) ? byte_nxt : 8'h00;
    end
  end

  // busy covers the start cycle, but stays high one cycle after the return to idle, where a start is taken as new
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_r != ST_IDLE) || start;
    end
  end
endmodule

// ---- hw/header_subcode_parser.sv ----
`timescale 1ns/1ps
module header_subcode_parser
  import framer_pkg::*;
(
  input  wire logic       mclk,            // byte clock
  input  wire logic       rst,             // sync reset
  stream_if.sink          rx,              // byte stream in
  output logic [2:0]      section_type,    // last block section type
  output logic [3:0]      seq_num,         // last block sequence number
  output logic [1:0]      channel,         // last block channel
  output logic [7:0]      block_number,    // last block number
  output logic            sys50,           // sequence count flag
  output logic [2:0]      track_app_code,  // header byte 4
  output logic [2:0]      app_code_one,    // header byte 5
  output logic [2:0]      app_code_two,    // header byte 6
  output logic [2:0]      app_code_three,  // header byte 7
  output logic [2:0]      valid_flags,     // {subcode, picture, audio}, 0 valid
  output logic            half_flag,       // last sub-block half flag
  output logic [3:0]      ssb_number,      // last sub-block number
  output logic            pack_stb,        // pulse: pack complete
  output logic [7:0]      pack_header,     // pack header code
  output logic [31:0]     pack_body,       // pack bytes 1..4
  output logic            id_stb,          // pulse: identifier complete
  output logic            malformed        // pulse with id_stb: bad identifier
);
  logic [6:0] pos_r;
  logic [2:0] sct_r;
  logic [6:0] rel;
  logic [6:0] cur;
  logic [3:0] maxseq;

  assign cur    = rx.sob ? 7'h00 : pos_r;
  assign rel    = cur - 7'(ID_BYTES);
  assign maxseq = sys50 ? MAX_SEQ_50 : MAX_SEQ_60;

  always_ff @(posedge mclk) begin
    if (rst)
      pos_r <= 7'h00;
    else if (rx.valid)
      pos_r <= (cur == LAST_BYTE) ? 7'h00 : cur + 7'h01;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sct_r <= 3'h7; section_type <= 3'h7; seq_num <= 4'h0; channel <= 2'h0;
      block_number <= 8'h00; id_stb <= 1'b0; malformed <= 1'b0;
    end else begin
      id_stb    <= 1'b0;
      malformed <= 1'b0;
      if (rx.valid && cur == 7'h00) begin
        sct_r        <= rx.data[7:5];
        section_type <= rx.data[7:5];
      end
      if (rx.valid && cur == 7'h01) begin
        seq_num <= rx.data[7:4];
        channel <= bits_to_chan(rx.data[3:2]);
      end
      if (rx.valid && cur == 7'h02) begin
        block_number <= rx.data;
        id_stb       <= 1'b1;
        malformed    <= (sct_r > SECT_VIDEO) || (seq_num > maxseq);
      end
    end
  end

  // header payload, bits marked arbitrary are ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      sys50 <= 1'b0; track_app_code <= APP_UNKNOWN; app_code_one <= APP_UNKNOWN;
      app_code_two <= APP_UNKNOWN; app_code_three <= APP_UNKNOWN; valid_flags <= 3'h7;
    end else if (rx.valid && sct_r == SECT_HEADER) begin
      case (cur)
        7'h03: sys50 <= rx.data[7];
        7'h04: track_app_code <= rx.data[2:0];
        7'h05: begin app_code_one <= rx.data[2:0]; valid_flags[0] <= rx.data[7]; end
        7'h06: begin app_code_two <= rx.data[2:0]; valid_flags[1] <= rx.data[7]; end
        7'h07: begin app_code_three <= rx.data[2:0]; valid_flags[2] <= rx.data[7]; end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      half_flag <= 1'b1; ssb_number <= 4'hf; pack_stb <= 1'b0;
      pack_header <= PACK_NO_INFO; pack_body <= '1;
    end else begin
      pack_stb <= 1'b0;
      if (rx.valid && sct_r == SECT_SUBCODE && cur > 7'h02 && cur < SUB_AREA_END) begin
        case (rel[2:0])
          3'h0: half_flag  <= rx.data[7];
          3'h1: ssb_number <= rx.data[3:0];
          3'h2: ;
          3'h3: pack_header <= rx.data;
          default: begin
            pack_body <= {pack_body[23:0], rx.data};
            pack_stb  <= (rel[2:0] == 3'h7);
          end
        endcase
      end
    end
  end
endmodule

// ---- dv/framer_checker.sv ----
`timescale 1ns/1ps
module framer_checker
  import framer_pkg::*;
(
  input wire logic       mclk,  // byte clock
  input wire logic       rst,   // sync reset
  input wire logic       valid, // byte present
  input wire logic       sob,   // block start
  input wire logic [7:0] data   // byte
);
  logic [6:0] pos_r;  // index of the current byte when not sob
  logic [2:0] sect_r;
  logic       blk_r;
  logic [6:0] off;
  logic       pay;
  assign off = pos_r - 7'h3;
  assign pay = valid && !sob;
  always_ff @(posedge mclk) begin
    if (rst) pos_r <= 7'h0;
    else if (valid && sob) pos_r <= 7'h1;
    else if (valid) pos_r <= pos_r + 7'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sect_r <= 3'h7;
      blk_r  <= 1'b0;
    end else begin
      if (valid && sob) sect_r <= data[7:5];
      if (pay && pos_r == 7'h2) blk_r <= data[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_START_SOB: assert property ($rose(valid) |-> sob)
    else $error("stream starts without block start");
  AST_BLOCK_LEN: assert property (pay |-> pos_r != 7'h0 && pos_r <= LAST_BYTE)
    else $error("block longer than 80 bytes");
  AST_BLOCK_WRAP: assert property (valid && pos_r == 7'h50 |-> sob)
    else $error("byte after block end without block start");
  AST_ID0: assert property (valid && sob |-> data[7:5] < 3'h5 && data[4])
    else $error("bad section type or reserved bit");
  AST_ID1: assert property (pay && pos_r == 7'h1 |-> data[1:0] == 2'h3 && data[7:4] <= MAX_SEQ_50)
    else $error("bad second id byte");
  AST_ORDER: assert property (valid && sob && data[7:5] == SECT_HEADER |->
    ##80 (sob && data[7:5] == SECT_SUBCODE) ##80 (sob && data[7:5] == SECT_SUBCODE))
    else $error("header not followed by two subcode blocks");
  AST_HDR_B3: assert property (pay && sect_r == SECT_HEADER && pos_r == 7'h3 |-> data[6:0] == 7'h3f)
    else $error("header byte 3 wrong");
  AST_HDR_RES: assert property (pay && sect_r == SECT_HEADER && pos_r inside {[4:7]} |-> data[6:3] == 4'hf)
    else $error("header reserved bits not one");
  AST_HDR_FILL: assert property (pay && sect_r == SECT_HEADER && pos_r > HDR_LAST_ACTIVE |-> data == FILL_BYTE)
    else $error("header fill byte wrong");
  AST_SSB_FF: assert property (pay && sect_r == SECT_SUBCODE && pos_r < SUB_AREA_END && off[2:0] == 3'h2
    |-> data == FILL_BYTE)
    else $error("sub-block filler byte wrong");
  AST_SSB_NUM: assert property (pay && sect_r == SECT_SUBCODE && pos_r > 7'h2 && pos_r < SUB_AREA_END
    && off[2:0] == 3'h1 |-> data[3:0] == (blk_r ? 4'h6 : 4'h0) + {1'b0, off[5:3]})
    else $error("sub-block number wrong");
  AST_SUB_TAIL: assert property (pay && sect_r == SECT_SUBCODE && pos_r >= SUB_AREA_END |-> data == FILL_BYTE)
    else $error("subcode reserved area wrong");
  cover property (valid && sob && data[7:5] == SECT_SUBCODE);
  cover property (pay && sect_r == SECT_SUBCODE && off[2:0] == 3'h3 && data == PACK_BIN_GROUP);
  cover property ($fell(valid));
endmodule

// ---- dv/dif_header_subcode_framer_test.sv ----
`timescale 1ns/1ps
module dif_header_subcode_framer_test;
  import framer_pkg::*;
  logic        mclk, rst, start, s50, known, hunk, fst, busy, last50;
  logic [3:0]  seq, p_seq, p_ssb;
  logic [1:0]  ch, p_ch;
  logic [2:0]  vf, p_sect, p_ta, p_a1, p_a2, p_a3, p_vf;
  logic [31:0] tc, bg, p_pb;
  logic [7:0]  p_bn, p_ph;
  logic        p_s50, p_half, p_pstb, p_istb, p_bad;
  logic [7:0]  hdr_a [12];
  logic [31:0] body_a [12];
  int          miscompares, n_tests, nbytes, nbad;
  stream_if link();
  header_subcode_framer i_header_subcode_framer (.mclk(mclk), .rst(rst), .start(start), .sys50(s50),
    .seq_num(seq), .channel(ch), .src_known(known), .half_unknown(hunk), .audio_valid_flag(vf[0]),
    .picture_valid_flag(vf[1]), .subcode_valid_flag(vf[2]), .frame_start(fst), .tc_body(tc),
    .bg_body(bg), .busy(busy), .tx(link));
  header_subcode_parser i_header_subcode_parser (.mclk(mclk), .rst(rst), .rx(link), .section_type(p_sect),
    .seq_num(p_seq), .channel(p_ch), .block_number(p_bn), .sys50(p_s50), .track_app_code(p_ta),
    .app_code_one(p_a1), .app_code_two(p_a2), .app_code_three(p_a3), .valid_flags(p_vf),
    .half_flag(p_half), .ssb_number(p_ssb), .pack_stb(p_pstb), .pack_header(p_ph), .pack_body(p_pb),
    .id_stb(p_istb), .malformed(p_bad));
  framer_checker i_framer_checker (.mclk(mclk), .rst(rst), .valid(link.valid), .sob(link.sob),
    .data(link.data));
  always #2 mclk = ~mclk;
  // sample registered outputs mid-cycle
  always @(negedge mclk) begin
    if (link.valid) nbytes++;
    if (p_istb && p_bad) nbad++;
    if (p_pstb && p_ssb < 4'hc) begin
      hdr_a[p_ssb] = p_ph;
      body_a[p_ssb] = p_pb;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic frame(input logic f50, input logic [3:0] sq, input logic [1:0] c, input logic kn,
                       input logic hu, input logic [2:0] flags, input bit again);
    int   n;
    int   k;
    logic first;
    @(negedge mclk);
    {s50, seq, ch, known, hunk, vf} = {f50, sq, c, kn, hu, flags};
    tc = {28'h1234567, sq};
    bg = {sq, 28'h89abcde};
    hdr_a = '{default: 8'h0};
    body_a = '{default: 32'h0};
    nbytes = 0;
    nbad = 0;
    fst = 1'b1;
    start = 1'b1;
    @(negedge mclk);
    fst = 1'b0;
    start = 1'b0;
    n = 0;
    while (busy && n < 300) begin
      @(negedge mclk);
      n++;
      start = again && n == 40;
    end
    repeat (3) @(negedge mclk);
    first = sq <= (f50 ? HALF_LAST_50 : HALF_LAST_60);
    chk("bytes", 32'd240, nbytes);
    chk("section", SECT_SUBCODE, p_sect);
    chk("block", 32'h1, p_bn);
    chk("seq", sq, p_seq);
    chk("chan", c, p_ch);
    chk("rate", f50, p_s50);
    chk("apps", {4{kn ? 3'h1 : 3'h7}}, {p_ta, p_a1, p_a2, p_a3});
    chk("flags", flags, p_vf);
    chk("half", hu | first, p_half);
    chk("ssb", 32'hb, p_ssb);
    // the header id is judged against the rate flag of the previous header
    chk("bad", 32'((sq > (last50 ? MAX_SEQ_50 : MAX_SEQ_60)) + 2 * (sq > (f50 ? MAX_SEQ_50 : MAX_SEQ_60))), nbad);
    last50 = f50;
    for (int i = 0; i < 12; i++) begin
      k = (i == 3 || i == 9) ? 1 : (first && (i == 5 || i == 11)) ? 1 : (first && (i == 4 || i == 10)) ? 2 : 0;
      chk("pack hdr", k == 1 ? 8'h13 : k == 2 ? 8'h14 : 8'hff, hdr_a[i]);
      chk("pack body", k == 1 ? tc : k == 2 ? bg : 32'hffffffff, body_a[i]);
    end
    $display("frame seq %0d rate %0d done", sq, f50);
  endtask
  initial begin
    {mclk, start, s50, known, hunk, fst, last50, seq, ch, vf, tc, bg} = '0;
    rst = 1'b1;
    {miscompares, n_tests, nbytes, nbad} = '0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    frame(1'b0, 4'h0, 2'h0, 1'b1, 1'b0, 3'h0, 1'b0);
    // second start while busy must be ignored
    frame(1'b0, 4'h5, 2'h1, 1'b0, 1'b0, 3'h5, 1'b1);
    frame(1'b1, 4'h5, 2'h2, 1'b1, 1'b0, 3'h2, 1'b0);
    frame(1'b1, 4'hb, 2'h3, 1'b1, 1'b1, 3'h7, 1'b0);
    frame(1'b1, 4'h6, 2'h0, 1'b0, 1'b0, 3'h1, 1'b0);
    frame(1'b0, 4'hb, 2'h1, 1'b1, 1'b1, 3'h0, 1'b0);
    results();
  end
  initial begin
    #20000;
    miscompares++;
    results();
  end
endmodule
